// ==== tb/kptc_keypad_model.sv ====
// kptc_keypad_model.sv: 4x4 key matrix behind the scanner rows and columns.
// assumes active-low row drive and pulled-up column lines.
`timescale 1ns/1ps

module kptc_keypad_model (
    input wire [3:0] row_drive_n,
    input wire [15:0] held_keys,
    output logic [3:0] col_sense_n
);
    // ideal diodes: no ghost keys, ghosting is only tolerated
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            col_sense_n[c] = 1'b1;
            for (int r = 0; r < 4; r++)
                if (!row_drive_n[r] && held_keys[4*r+c])
                    col_sense_n[c] = 1'b0;
        end
    end
endmodule // kptc_keypad_model

// ==== tb/kptc_regs_asserts.sv ====
// kptc_regs_asserts.sv: port-level checks on kptc_regs, attached by bind.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module kptc_regs_asserts (
    input wire clk_sys,
    input wire nrst,
    input wire reg_page,
    input wire [5:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire [3:0] col_sense_n,
    input wire [3:0] row_drive_n,
    input wire key_event_line_n,
    input wire result_pending_line,
    input wire touch_precharge_start,
    input wire touch_sense_start,
    input wire touch_precharge_done,
    input wire touch_sense_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire ctl_sel = reg_page && reg_addr == 6'h01;
    wire scanning = row_drive_n != 4'hF && row_drive_n != 4'h0;

    rst_reg_ones_a: assert property (reg_rd && reg_page && reg_addr == 6'h04
        |=> reg_rdata == 16'hFFFF)
        else $error("reset register read is not all ones");
    mirror_zero_a: assert property (reg_rd && reg_page && reg_addr == 6'h06
        |=> reg_rdata[14:0] == 15'h0000)
        else $error("mirror reserved bits not zero");
    // pin held steady so either sampling delay of the mirror gives the same bit
    mirror_bit_a: assert property (reg_rd && reg_page && reg_addr == 6'h06
        && $past(nrst) && $past(nrst, 2)
        && $stable(result_pending_line) |=> reg_rdata[15] == $past(result_pending_line, 2))
        else $error("mirror bit differs from pending line");
    hit_line_a: assert property (reg_rd && ctl_sel |=> reg_rdata[15] != $past(key_event_line_n)
        && reg_rdata[10:0] == 11'h000)
        else $error("hit flag not inverse of key line");
    busy_report_a: assert property (reg_rd && ctl_sel && !key_event_line_n |=> !reg_rdata[14])
        else $error("idle flag set while key reported");
    stop_abort_a: assert property (reg_wr && ctl_sel && reg_wdata[14]
        |=> row_drive_n == 4'hF && key_event_line_n)
        else $error("stop write did not abort scanning");
    start_rows_a: assert property (reg_wr && ctl_sel && !reg_wdata[14] && row_drive_n == 4'hF
        |=> row_drive_n == 4'h0)
        else $error("start write did not drive all rows");
    row_hold_a: assert property ($changed(row_drive_n) && scanning
        |=> (row_drive_n == $past(row_drive_n) || row_drive_n == 4'hF) [*4])
        else $error("scan row not held for five cycles");
    pre_quiet_a: assert property (touch_precharge_start |=> !touch_precharge_done [*8])
        else $error("precharge done far too early");
    sns_pulse_a: assert property (touch_sense_done |=> !touch_sense_done)
        else $error("sense done longer than one cycle");
    soft_reset_a: assert property (reg_wr && reg_page && reg_addr == 6'h04 && reg_wdata == 16'hBB00
        |-> ##2 row_drive_n == 4'hF && key_event_line_n)
        else $error("software reset left scanner active");

    cover property ($fell(key_event_line_n));
    cover property (reg_wr && ctl_sel && reg_wdata[14] && !key_event_line_n);
    cover property (reg_wr && reg_page && reg_addr == 6'h04 && reg_wdata == 16'hBB00);
endmodule // kptc_regs_asserts

bind kptc_regs kptc_regs_asserts u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .col_sense_n(col_sense_n),
    .row_drive_n(row_drive_n), .key_event_line_n(key_event_line_n), .result_pending_line(result_pending_line),
    .touch_precharge_start(touch_precharge_start), .touch_sense_start(touch_sense_start),
    .touch_precharge_done(touch_precharge_done), .touch_sense_done(touch_sense_done)
);

// ==== tb/kptc_regs_tb.sv ====
// kptc_regs_tb.sv: self-checking bench for kptc_regs with a keypad matrix model.
// assumes CYC_PER_US set to 1, so one microsecond is one clock cycle.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module kptc_regs_tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic reg_page = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] held_keys = 16'h0000;
    logic [3:0] col_sense_n;
    logic [3:0] row_drive_n;
    logic key_event_line_n;
    logic result_pending_line = 1'b1;
    logic touch_precharge_start = 1'b0;
    logic touch_sense_start = 1'b0;
    logic touch_precharge_done;
    logic touch_sense_done;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    int pre_us[8] = '{20, 84, 276, 340, 1044, 1108, 1300, 1364};
    int sns_us[8] = '{32, 96, 544, 608, 2080, 2144, 2592, 2656};

    kptc_regs #(.CYC_PER_US(1)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .col_sense_n(col_sense_n),
        .row_drive_n(row_drive_n), .key_event_line_n(key_event_line_n), .result_pending_line(result_pending_line),
        .touch_precharge_start(touch_precharge_start), .touch_sense_start(touch_sense_start),
        .touch_precharge_done(touch_precharge_done), .touch_sense_done(touch_sense_done)
    );
    kptc_keypad_model u_keys (.row_drive_n(row_drive_n), .held_keys(held_keys), .col_sense_n(col_sense_n));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ceiling well above the ~43k cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 80000) begin
            fails++;
            end_sim();
        end
    end

    task automatic wr(input logic pg, input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_page = pg;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic pg, input logic [5:0] a, input logic [15:0] exp);
        @(negedge clk_sys);
        reg_page = pg;
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        `CHK(nm, exp, reg_rdata)
    endtask

    task automatic timer_chk(input bit sns, input int n);
        int cnt;
        cnt = 0;
        @(negedge clk_sys);
        if (sns)
            touch_sense_start = 1'b1;
        else
            touch_precharge_start = 1'b1;
        @(negedge clk_sys);
        touch_sense_start = 1'b0;
        touch_precharge_start = 1'b0;
        while ((sns ? touch_sense_done : touch_precharge_done) !== 1'b1 && cnt < 3000) begin
            @(negedge clk_sys);
            cnt++;
        end
        `CHK("interval cycles", n, cnt)
    endtask

    task automatic wait_line(input logic lvl, input int lo, input int hi);
        int cnt;
        cnt = 0;
        while (key_event_line_n !== lvl && cnt <= hi) begin
            @(negedge clk_sys);
            cnt++;
        end
        `CHK("key line delay in window", 1'b1, cnt >= lo && cnt <= hi)
    endtask

    initial begin
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        rd_chk("control", 1'b1, 6'h01, 16'h4000);
        rd_chk("timing", 1'b1, 6'h05, 16'h0000);
        rd_chk("mask", 1'b1, 6'h10, 16'h0000);
        rd_chk("result", 1'b0, 6'h04, 16'h0000);
        rd_chk("mirror", 1'b1, 6'h06, 16'h8000);
        rd_chk("reset reg", 1'b1, 6'h04, 16'hFFFF);
        rd_chk("reserved 1/3F", 1'b1, 6'h3F, 16'hFFFF);
        rd_chk("reserved 0/00", 1'b0, 6'h00, 16'hFFFF);
        result_pending_line = 1'b0;
        repeat (3) @(negedge clk_sys);
        rd_chk("mirror pending", 1'b1, 6'h06, 16'h0000);
        result_pending_line = 1'b1;
        wr(1'b1, 6'h06, 16'h0000);
        repeat (3) @(negedge clk_sys);
        rd_chk("mirror idle", 1'b1, 6'h06, 16'h8000);
        for (int i = 0; i < 8; i++) begin
            wr(1'b1, 6'h05, {10'h000, i[2:0], 3'h7 - i[2:0]});
            rd_chk("timing", 1'b1, 6'h05, {10'h000, i[2:0], 3'h7 - i[2:0]});
            timer_chk(1'b0, pre_us[i]);
            timer_chk(1'b1, sns_us[7 - i]);
        end
        held_keys = 16'h2140;
        wr(1'b1, 6'h01, 16'h0000);
        wait_line(1'b0, 2000, 2060);
        rd_chk("result", 1'b0, 6'h04, 16'h2140);
        rd_chk("control hit", 1'b1, 6'h01, 16'h8000);
        wr(1'b1, 6'h10, 16'h2140);
        wait_line(1'b1, 0, 2100);
        rd_chk("result masked", 1'b0, 6'h04, 16'h0000);
        rd_chk("mask", 1'b1, 6'h10, 16'h2140);
        wr(1'b1, 6'h10, 16'h0040);
        wait_line(1'b0, 0, 2100);
        rd_chk("result part", 1'b0, 6'h04, 16'h2100);
        wr(1'b1, 6'h01, 16'h4000);
        `CHK("line after stop", 1'b1, key_event_line_n)
        rd_chk("control stop", 1'b1, 6'h01, 16'h4000);
        // every settle code stored while stopped; long codes are too slow to time here
        for (int i = 0; i < 8; i++) begin
            wr(1'b1, 6'h01, {2'h1, i[2:0], 11'h000});
            rd_chk("settle code", 1'b1, 6'h01, {2'h1, i[2:0], 11'h000});
        end
        wr(1'b1, 6'h10, 16'h0000);
        held_keys = 16'h8001;
        wr(1'b1, 6'h01, 16'h0800);
        rd_chk("control busy", 1'b1, 6'h01, 16'h0800);
        wait_line(1'b0, 9900, 10060);
        rd_chk("result corners", 1'b0, 6'h04, 16'h8001);
        held_keys = 16'h0000;
        wait_line(1'b1, 0, 10100);
        rd_chk("control idle", 1'b1, 6'h01, 16'h4800);
        wr(1'b1, 6'h05, 16'h002A);
        wr(1'b1, 6'h10, 16'hFFFF);
        wr(1'b1, 6'h04, 16'hBB00);
        repeat (2) @(negedge clk_sys);
        rd_chk("control", 1'b1, 6'h01, 16'h4000);
        rd_chk("timing", 1'b1, 6'h05, 16'h0000);
        rd_chk("mask", 1'b1, 6'h10, 16'h0000);
        rd_chk("result", 1'b0, 6'h04, 16'h0000);
        end_sim();
    end
endmodule // kptc_regs_tb

// ==== verilog/kptc_interval_timer.v ====
// kptc_interval_timer.v: loadable down counter that pulses done a set number of cycles after load.
// assumes a synchronous active-low reset and load values of at least one.
`timescale 1ns/1ps

module kptc_interval_timer #(
    parameter CNT_W = 24
) (
    input wire clk_sys,
    input wire nrst,
    input wire load,
    input wire abort,
    input wire [CNT_W-1:0] load_value,
    output reg busy,
    output reg done
);

    reg [CNT_W-1:0] cnt;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            cnt <= {CNT_W{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                cnt <= {CNT_W{1'b0}};
                busy <= 1'b0;
            end else if (load) begin
                cnt <= load_value;
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    cnt <= {CNT_W{1'b0}};
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // kptc_interval_timer

// ==== verilog/kptc_map.vh ====
// kptc_map.vh: register map, field layout, reset values and timing for the keypad/touch control block.
// assumes inclusion by bare name from design files; definitions only.
`ifndef KPTC_MAP_VH
`define KPTC_MAP_VH

`define KPTC_CLK_PERIOD_NS 10

// register pages and addresses
`define KPTC_PAGE_DATA 1'h0
`define KPTC_PAGE_CTRL 1'h1
`define KPTC_ADDR_SCAN_RESULT 6'h04
`define KPTC_ADDR_KEYPAD_CONTROL 6'h01
`define KPTC_ADDR_SW_RESET 6'h04
`define KPTC_ADDR_TOUCH_TIMING 6'h05
`define KPTC_ADDR_DATA_READY 6'h06
`define KPTC_ADDR_KEY_IGNORE 6'h10

// keypad_control fields
`define KPTC_KC_HIT_BIT 15
`define KPTC_KC_IDLE_BIT 14
`define KPTC_KC_SETTLE_HI 13
`define KPTC_KC_SETTLE_LO 11
// touch_detect_timing fields
`define KPTC_TT_PRE_HI 5
`define KPTC_TT_PRE_LO 3
`define KPTC_TT_SNS_HI 2
`define KPTC_TT_SNS_LO 0
// data_ready_mirror field
`define KPTC_DR_PENDING_BIT 15

// values
`define KPTC_SW_RESET_CODE 16'hBB00
`define KPTC_READ_ALL_ONES 16'hFFFF
`define KPTC_ZERO_WORD 16'h0000
`define KPTC_SEL_RESET 3'h0
`define KPTC_MASK_RESET 16'h0000
`define KPTC_SETTLE_LOW_CYCLES 4'h4

// precharge times in microseconds
`define KPTC_PRE_T0_US 20
`define KPTC_PRE_T1_US 84
`define KPTC_PRE_T2_US 276
`define KPTC_PRE_T3_US 340
`define KPTC_PRE_T4_US 1044
`define KPTC_PRE_T5_US 1108
`define KPTC_PRE_T6_US 1300
`define KPTC_PRE_T7_US 1364
// sense times in microseconds
`define KPTC_SNS_T0_US 32
`define KPTC_SNS_T1_US 96
`define KPTC_SNS_T2_US 544
`define KPTC_SNS_T3_US 608
`define KPTC_SNS_T4_US 2080
`define KPTC_SNS_T5_US 2144
`define KPTC_SNS_T6_US 2592
`define KPTC_SNS_T7_US 2656
// debounce times in milliseconds
`define KPTC_DB_T0_MS 2
`define KPTC_DB_T1_MS 10
`define KPTC_DB_T2_MS 20
`define KPTC_DB_T3_MS 50
`define KPTC_DB_T4_MS 60
`define KPTC_DB_T5_MS 80
`define KPTC_DB_T6_MS 100
`define KPTC_DB_T7_MS 120

`endif

// ==== verilog/kptc_regs.v ====
// kptc_regs.v: keypad scanner control, key ignore mask, touch precharge/sense timers, data-ready
// mirror and keyed software reset, reached through the decoded word port of the serial front end.
// assumes the serial front end delivers one-cycle read/write strobes with page and address.
//
// What this block does
// - precharge time from 3-bit code, default 20us
// - sense wait from 3-bit code, default 32us
// - hit flag reads inverse of key event line
// - idle flag reads 0 busy, 1 idle
// - writing 0 starts continuous keypad scanning
// - writing 1 stops and aborts scanning immediately
// - 3-bit debounce code selects 2 to 120ms
// - ignore bit set hides that key; resets zero
// - ignored keys never assert key event line
// - key bit is row times four plus column
// - each scan writes one bit per pressed key
// - plain matrix scan, ghost fourth corner allowed
// - read-only mirror of the result pending line
// - mirror reserved bits read as zero
// - code BB00 to reset register restores defaults
// - reset register and reserved addresses read FFFF
// - scan result clears to zero on reset
`timescale 1ns/1ps

`include "kptc_map.vh"

module kptc_regs #(
    parameter CNT_W = 24,
    parameter CYC_PER_US = 1000 / `KPTC_CLK_PERIOD_NS
) (
    input wire clk_sys,
    input wire nrst,
    input wire reg_page,
    input wire [5:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire [3:0] col_sense_n,
    output reg [3:0] row_drive_n,
    output reg key_event_line_n,
    input wire result_pending_line,
    input wire touch_precharge_start,
    input wire touch_sense_start,
    output wire touch_precharge_done,
    output wire touch_sense_done
);

    localparam ST_OFF = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_DEBOUNCE = 3'h2;
    localparam ST_SCAN = 3'h3;
    localparam ST_REPORT = 3'h4;
    localparam ST_RESCAN = 3'h5;

    reg [2:0] precharge_sel;
    reg [2:0] touch_probe_wait;
    reg [2:0] key_settle_interval;
    reg [15:0] button_ignore_bits;
    reg [15:0] pressed_button_bits;
    reg key_hit_flag;
    reg result_pending_mirror;
    reg soft_rst;
    reg [2:0] state;
    reg [1:0] row_idx;
    reg [3:0] settle_cnt;
    reg [15:0] scan_acc;

    wire rst_n = nrst & ~soft_rst;
    wire wr_ctrl = reg_wr && (reg_page == `KPTC_PAGE_CTRL);
    wire wr_kc = wr_ctrl && (reg_addr == `KPTC_ADDR_KEYPAD_CONTROL);
    wire scan_stop = wr_kc && reg_wdata[`KPTC_KC_IDLE_BIT];
    wire scan_start = wr_kc && !reg_wdata[`KPTC_KC_IDLE_BIT];
    wire scanner_idle_flag = (state == ST_OFF) || (state == ST_WAIT);
    wire any_col_low = ~&col_sense_n;
    wire [15:0] masked_acc = scan_acc & ~button_ignore_bits;
    wire db_done;
    wire db_busy;
    wire db_load = (state == ST_WAIT && any_col_low) || (state == ST_REPORT && masked_acc != `KPTC_ZERO_WORD);

    function [CNT_W-1:0] precharge_cycles;
        input [2:0] code;
        reg [31:0] t;
        begin
            case (code)
                3'h0: t = `KPTC_PRE_T0_US * CYC_PER_US;
                3'h1: t = `KPTC_PRE_T1_US * CYC_PER_US;
                3'h2: t = `KPTC_PRE_T2_US * CYC_PER_US;
                3'h3: t = `KPTC_PRE_T3_US * CYC_PER_US;
                3'h4: t = `KPTC_PRE_T4_US * CYC_PER_US;
                3'h5: t = `KPTC_PRE_T5_US * CYC_PER_US;
                3'h6: t = `KPTC_PRE_T6_US * CYC_PER_US;
                default: t = `KPTC_PRE_T7_US * CYC_PER_US;
            endcase
            precharge_cycles = t[CNT_W-1:0];
        end
    endfunction

    function [CNT_W-1:0] sense_cycles;
        input [2:0] code;
        reg [31:0] t;
        begin
            case (code)
                3'h0: t = `KPTC_SNS_T0_US * CYC_PER_US;
                3'h1: t = `KPTC_SNS_T1_US * CYC_PER_US;
                3'h2: t = `KPTC_SNS_T2_US * CYC_PER_US;
                3'h3: t = `KPTC_SNS_T3_US * CYC_PER_US;
                3'h4: t = `KPTC_SNS_T4_US * CYC_PER_US;
                3'h5: t = `KPTC_SNS_T5_US * CYC_PER_US;
                3'h6: t = `KPTC_SNS_T6_US * CYC_PER_US;
                default: t = `KPTC_SNS_T7_US * CYC_PER_US;
            endcase
            sense_cycles = t[CNT_W-1:0];
        end
    endfunction

    function [CNT_W-1:0] debounce_cycles;
        input [2:0] code;
        reg [31:0] t;
        begin
            case (code)
                3'h0: t = `KPTC_DB_T0_MS * 1000 * CYC_PER_US;
                3'h1: t = `KPTC_DB_T1_MS * 1000 * CYC_PER_US;
                3'h2: t = `KPTC_DB_T2_MS * 1000 * CYC_PER_US;
                3'h3: t = `KPTC_DB_T3_MS * 1000 * CYC_PER_US;
                3'h4: t = `KPTC_DB_T4_MS * 1000 * CYC_PER_US;
                3'h5: t = `KPTC_DB_T5_MS * 1000 * CYC_PER_US;
                3'h6: t = `KPTC_DB_T6_MS * 1000 * CYC_PER_US;
                default: t = `KPTC_DB_T7_MS * 1000 * CYC_PER_US;
            endcase
            debounce_cycles = t[CNT_W-1:0];
        end
    endfunction

    // touch detect intervals, loaded from the code selected at start
    kptc_interval_timer #(.CNT_W(CNT_W)) u_precharge (
        .clk_sys(clk_sys),
        .nrst(rst_n),
        .load(touch_precharge_start),
        .abort(1'b0),
        .load_value(precharge_cycles(precharge_sel)),
        .busy(),
        .done(touch_precharge_done)
    );

    kptc_interval_timer #(.CNT_W(CNT_W)) u_sense (
        .clk_sys(clk_sys),
        .nrst(rst_n),
        .load(touch_sense_start),
        .abort(1'b0),
        .load_value(sense_cycles(touch_probe_wait)),
        .busy(),
        .done(touch_sense_done)
    );

    // also paces the gap between repeated scans while a key is held
    kptc_interval_timer #(.CNT_W(CNT_W)) u_debounce (
        .clk_sys(clk_sys),
        .nrst(rst_n),
        .load(db_load),
        .abort(scan_stop),
        .load_value(debounce_cycles(key_settle_interval)),
        .busy(db_busy),
        .done(db_done)
    );

    // configuration registers and software reset
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            precharge_sel <= `KPTC_SEL_RESET;
            touch_probe_wait <= `KPTC_SEL_RESET;
            key_settle_interval <= `KPTC_SEL_RESET;
            button_ignore_bits <= `KPTC_MASK_RESET;
            result_pending_mirror <= 1'b1;
            soft_rst <= 1'b0;
        end else begin
            result_pending_mirror <= result_pending_line;
            soft_rst <= wr_ctrl && (reg_addr == `KPTC_ADDR_SW_RESET)
                && (reg_wdata == `KPTC_SW_RESET_CODE);
            if (wr_kc) begin
                key_settle_interval <= reg_wdata[`KPTC_KC_SETTLE_HI:`KPTC_KC_SETTLE_LO];
            end
            if (wr_ctrl && reg_addr == `KPTC_ADDR_TOUCH_TIMING) begin
                precharge_sel <= reg_wdata[`KPTC_TT_PRE_HI:`KPTC_TT_PRE_LO];
                touch_probe_wait <= reg_wdata[`KPTC_TT_SNS_HI:`KPTC_TT_SNS_LO];
            end
            if (wr_ctrl && reg_addr == `KPTC_ADDR_KEY_IGNORE) begin
                button_ignore_bits <= reg_wdata;
            end
        end
    end

    // keypad scanner: wait for press, debounce, walk rows, report, repeat while held
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_OFF;
            row_idx <= 2'h0;
            settle_cnt <= 4'h0;
            scan_acc <= `KPTC_ZERO_WORD;
            pressed_button_bits <= `KPTC_ZERO_WORD;
            key_hit_flag <= 1'b0;
            key_event_line_n <= 1'b1;
            row_drive_n <= 4'hF;
        end else if (scan_stop) begin
            // abort wins even with a key held; rows released at once
            state <= ST_OFF;
            row_drive_n <= 4'hF;
            key_hit_flag <= 1'b0;
            key_event_line_n <= 1'b1;
        end else begin
            case (state)
                ST_OFF: begin
                    row_drive_n <= 4'hF;
                    if (scan_start) begin
                        state <= ST_WAIT;
                        row_drive_n <= 4'h0;
                    end
                end
                ST_WAIT: begin
                    row_drive_n <= 4'h0;
                    if (any_col_low) begin
                        state <= ST_DEBOUNCE;
                    end
                end
                ST_DEBOUNCE: begin
                    if (db_done) begin
                        if (any_col_low) begin
                            state <= ST_SCAN;
                            row_idx <= 2'h0;
                            settle_cnt <= `KPTC_SETTLE_LOW_CYCLES;
                            scan_acc <= `KPTC_ZERO_WORD;
                            row_drive_n <= 4'hE;
                        end else begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_SCAN: begin
                    // one row low at a time; a plain scan can show ghost corners
                    if (settle_cnt != 4'h0) begin
                        settle_cnt <= settle_cnt - 4'h1;
                    end else begin
                        scan_acc[{row_idx, 2'h0} +: 4] <= ~col_sense_n;
                        if (row_idx == 2'h3) begin
                            state <= ST_REPORT;
                            row_drive_n <= 4'h0;
                        end else begin
                            row_idx <= row_idx + 2'h1;
                            settle_cnt <= `KPTC_SETTLE_LOW_CYCLES;
                            row_drive_n <= ~(4'h1 << (row_idx + 2'h1));
                        end
                    end
                end
                ST_REPORT: begin
                    pressed_button_bits <= masked_acc;
                    if (masked_acc != `KPTC_ZERO_WORD) begin
                        key_hit_flag <= 1'b1;
                        key_event_line_n <= 1'b0;
                        state <= ST_RESCAN;
                    end else begin
                        key_hit_flag <= 1'b0;
                        key_event_line_n <= 1'b1;
                        state <= ST_WAIT;
                    end
                end
                ST_RESCAN: begin
                    if (db_done) begin
                        state <= ST_SCAN;
                        row_idx <= 2'h0;
                        settle_cnt <= `KPTC_SETTLE_LOW_CYCLES;
                        scan_acc <= `KPTC_ZERO_WORD;
                        row_drive_n <= 4'hE;
                    end
                end
                default: begin
                    state <= ST_OFF;
                    row_drive_n <= 4'hF;
                end
            endcase
        end
    end

    // register read port, one cycle after the strobe
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= `KPTC_ZERO_WORD;
        end else if (reg_rd) begin
            reg_rdata <= `KPTC_READ_ALL_ONES;
            if (reg_page == `KPTC_PAGE_DATA) begin
                if (reg_addr == `KPTC_ADDR_SCAN_RESULT) begin
                    reg_rdata <= pressed_button_bits;
                end
            end else begin
                case (reg_addr)
                    `KPTC_ADDR_KEYPAD_CONTROL: begin
                        reg_rdata <= {key_hit_flag, scanner_idle_flag, key_settle_interval,
                            11'h000};
                    end
                    `KPTC_ADDR_TOUCH_TIMING: begin
                        reg_rdata <= {10'h000, precharge_sel, touch_probe_wait};
                    end
                    `KPTC_ADDR_DATA_READY: begin
                        reg_rdata <= {result_pending_mirror, 15'h0000};
                    end
                    `KPTC_ADDR_KEY_IGNORE: begin
                        reg_rdata <= button_ignore_bits;
                    end
                    default: begin
                        reg_rdata <= `KPTC_READ_ALL_ONES;
                    end
                endcase
            end
        end
    end

endmodule // kptc_regs
